//--- testbench/rmc_bank_bench.sv
// Self-checking bench for the regulator mode control bank
`default_nettype none
module rmc_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DLY [1:3] = '{6, 12, 24};
	typedef struct {
		int         sel;
		int         idx;
		logic [7:0] exp;
	} rmc_note_t;
	logic        sys_clk = 1'b0;
	logic        nrst;
	logic        check_load;
	logic        reg_wr_en;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wr_data;
	logic [7:0]  reg_rd_data;
	logic [2:0]  pins;
	logic [2:0]  buck_main_ctrl [0:6];
	logic [4:0]  lin_nvm_output_voltage_code [0:7];
	logic [7:0]  lin_nvm_bypass;
	logic        lin3_nvm_termination;
	logic [2:0]  linear_startup_rank [0:7];
	logic [14:0] alt_mode_active;
	logic [14:0] regulator_force_off;
	logic [6:0]  buck_en_out;
	logic [1:0]  buck_mode_out [0:6];
	logic [7:0]  lin_en_out;
	logic [7:0]  lin_bypass_out;
	logic [4:0]  lin_output_voltage_code_out [0:7];
	logic        lin1_supply_sel_out;
	logic        lin3_termination_out;
	logic        obs_req = 1'b0;
	logic        obs_d = 1'b0;
	rmc_note_t   q [$];
	rmc_note_t   n;
	logic [7:0]  seen;
	int          errors = 0;
	int          n_checks = 0;
	int          cycles = 0;
	int          i;
	int          d;

	always #12.5 sys_clk = ~sys_clk;

	rmc_host host (.sys_clk, .reg_wr_en, .reg_addr, .reg_wr_data, .pins);

	rmc_bank #(.DLY_1P5_CYC(6), .DLY_3_CYC(12), .DLY_6_CYC(24)) uut (
		.sys_clk, .nrst, .check_load, .reg_wr_en, .reg_addr, .reg_wr_data,
		.reg_rd_data, .control_pin_one(pins[0]), .control_pin_two(pins[1]),
		.control_pin_three(pins[2]), .buck_main_ctrl, .lin_nvm_output_voltage_code,
		.lin_nvm_bypass, .lin3_nvm_termination, .linear_startup_rank,
		.alt_mode_active, .regulator_force_off, .buck_en_out, .buck_mode_out,
		.lin_en_out, .lin_bypass_out, .lin_output_voltage_code_out, .lin1_supply_sel_out,
		.lin3_termination_out);

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [7:0] s, input logic [7:0] e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// Queue a note; the monitor samples the output two edges later
	task automatic note(input int sel, input int idx, input logic [7:0] e);
		@(posedge sys_clk);
		q.push_back('{sel, idx, e});
		obs_req <= 1'b1;
		@(posedge sys_clk);
		obs_req <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.look(a);
		q.push_back('{0, 0, e});
		obs_req <= 1'b1;
		@(posedge sys_clk);
		obs_req <= 1'b0;
	endtask

	task automatic settle();
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic load();
		@(posedge sys_clk);
		check_load <= 1'b1;
		@(posedge sys_clk);
		check_load <= 1'b0;
	endtask

	// Shadow and main inputs: new random values, driven with nonblocking assignments
	task automatic shadow();
		lin_nvm_bypass <= 8'($urandom);
		lin3_nvm_termination <= 1'($urandom);
		for (i = 0; i < 8; i++)
		begin
			lin_nvm_output_voltage_code[i] <= 5'($urandom);
			linear_startup_rank[i] <= 3'($urandom_range(5, 0));
			if (i < 7)
				buck_main_ctrl[i] <= 3'($urandom_range(5, 0));
		end
	endtask

	task automatic defaults();
		for (i = 0; i < 7; i++)
			rd(rmc_pkg::BUCK_ALT_ADDR[i], {5'h00, buck_main_ctrl[i]});
		for (i = 0; i < 15; i++)
			rd(rmc_pkg::PIN_ADDR[i], rmc_pkg::PIN_RESET_VAL);
		for (i = 0; i < 8; i++)
		begin
			if (rmc_pkg::LIN_MAIN_PRESENT[i])
				rd(rmc_pkg::LIN_MAIN_ADDR[i],
					lin_def(i) & rmc_pkg::LIN_MAIN_MASK[i]);
			if (rmc_pkg::LIN_ALT_PRESENT[i])
				rd(rmc_pkg::LIN_ALT_ADDR[i],
					lin_def(i) & rmc_pkg::LIN_ALT_MASK[i]);
		end
	endtask

	function automatic logic [7:0] lin_def(input int k);
		return {(k == rmc_pkg::LIN3_IDX) & lin3_nvm_termination,
			lin_nvm_bypass[k], lin_nvm_output_voltage_code[k],
			linear_startup_rank[k] != 3'h0};
	endfunction

	always @(posedge sys_clk)
	begin
		obs_d <= obs_req;
		if (obs_d)
		begin
			n = q.pop_front();
			case (n.sel)
				0: seen = reg_rd_data;
				1: seen = {7'h00, alt_mode_active[n.idx]};
				2: seen = {7'h00, regulator_force_off[n.idx]};
				3: seen = {7'h00, lin_en_out[n.idx]};
				4: seen = {7'h00, lin_bypass_out[n.idx]};
				5: seen = {7'h00, lin3_termination_out};
				6: seen = {7'h00, lin1_supply_sel_out};
				7: seen = {7'h00, buck_en_out[n.idx]};
				9: seen = {3'h0, lin_output_voltage_code_out[n.idx]};
				default: seen = {6'h00, buck_mode_out[n.idx]};
			endcase
			check(seen, n.exp);
		end
	end

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors++;
			end_of_test();
		end
	end

	initial
	begin
		void'($urandom(39));
		nrst = 1'b0;
		check_load = 1'b0;
		shadow();
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		load();
		defaults();
		$display("defaults done");
		host.wr(8'h4F, 8'hFF);
		rd(8'h4F, 8'h7F);
		host.wr(8'h25, 8'hAA);
		rd(8'h25, 8'h00);
		host.wr(8'h23, 8'h07);
		rd(8'h23, {5'h00, buck_main_ctrl[0][2:1], 1'b1});
		$display("access done");
		host.wr(8'h24, 8'h05);
		for (i = 0; i < 3; i++)
		begin
			host.wr(8'h23, {5'h00, 2'(i), 1'b1});
			host.drive(3'h1);
			settle();
			note(1, 0, 8'h01);
			note(8, 0, 8'(i));
			note(7, 0, 8'h01);
			host.drive(3'h0);
			settle();
			note(8, 0, {6'h00, buck_main_ctrl[0][2:1]});
		end
		for (i = 0; i < 4; i++)
		begin
			host.wr(8'h24, {4'h0, 2'(i), 2'b01});
			host.drive(i == 0 ? 3'h7 : 3'h7 ^ 3'(1 << (i - 1)));
			settle();
			note(1, 0, 8'h00);
			host.drive(3'h7);
			settle();
			note(1, 0, {7'h00, i != 0});
			host.drive(3'h0);
			settle();
		end
		$display("select done");
		for (d = 1; d < 4; d++)
		begin
			host.wr(8'h24, {2'(d), 2'(d), 4'h5});
			host.drive(3'h1);
			repeat (DLY[d] - 4) @(posedge sys_clk);
			note(1, 0, 8'h00);
			repeat (4) @(posedge sys_clk);
			note(1, 0, 8'h01);
			host.drive(3'h0);
			repeat (DLY[d] - 4) @(posedge sys_clk);
			note(1, 0, 8'h01);
			repeat (4) @(posedge sys_clk);
			note(1, 0, 8'h00);
		end
		$display("delay done");
		host.wr(8'h4F, lin_def(1) ^ 8'h7F);
		host.wr(8'h51, 8'h06);
		host.drive(3'h1);
		settle();
		note(2, 8, 8'h01);
		note(3, 1, 8'h00);
		rd(8'h4F, lin_def(1) & 8'h7F);
		host.drive(3'h0);
		settle();
		note(2, 8, 8'h00);
		note(3, 1, 8'(linear_startup_rank[1] != 3'h0));
		note(9, 1, {3'h0, lin_nvm_output_voltage_code[1]});
		host.wr(8'h4F, 8'h40);
		settle();
		note(4, 1, 8'h01);
		note(9, 1, 8'h00);
		$display("pin reset done");
		host.wr(8'h52, 8'hC1);
		settle();
		note(5, 0, 8'h01);
		note(4, 2, 8'h00);
		host.wr(8'h4C, 8'h80);
		settle();
		note(6, 0, 8'h01);
		host.wr(8'h24, 8'hFF);
		load();
		rd(8'h24, 8'h00);
		rd(8'h4F, lin_def(1) & 8'h7F);
		$display("reload done");
		settle();
		nrst <= 1'b0;
		shadow();
		repeat (2) @(posedge sys_clk);
		nrst <= 1'b1;
		load();
		defaults();
		$display("second reset done");
		settle();
		end_of_test();
	end
endmodule
`default_nettype wire

//--- testbench/rmc_host.sv
// Host model: register writes, address select and control pins
`default_nettype none
module rmc_host (
	input  wire logic       sys_clk,
	output logic            reg_wr_en,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wr_data,
	output logic      [2:0] pins
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		reg_wr_en = 1'b0;
		reg_addr = 8'h00;
		reg_wr_data = 8'h00;
		pins = 3'h0;
	end
	// Strobe stands one cycle; data is inverted once released
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wr_data <= d;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		reg_wr_data <= ~d;
	endtask
	task automatic look(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
	endtask
	task automatic drive(input logic [2:0] v);
		@(posedge sys_clk);
		pins <= v;
	endtask
endmodule
`default_nettype wire

//--- verilog/rmc_bank.sv
// Regulator mode control register bank with control pin shift delays
//
// Behaviour
// RL1 - Buck mode: 00 high, 01 low, 10 fixed-frequency
// RL2 - Buck alternate defaults copy main enable and mode
// RL3 - Check-and-load reloads every register default
// RL4 - Rise shift delay: none, 1.5, 3, 6 ms
// RL5 - Fall shift delay: none, 1.5, 3, 6 ms
// RL6 - Pin select: none, pin one, two, three
// RL7 - Pin reset active: disable, reload regulator defaults
// RL8 - Pin reset inactive: follow main settings
// RL9 - Pin control chooses main or alternate settings
// RL10 - Alternate settings apply only in alternate mode
// RL11 - Linear bit 6 selects pass-through
// RL12 - Linear voltage code bits 5:1, default shadowed
// RL13 - Linear enable default set by nonzero rank
// RL14 - Linear alternate fields default to main
// RL15 - Linear one bit 7 picks supply input
// RL16 - Linear three bit 7 selects termination mode
// RL17 - Termination mode overrides pass-through
// RL18 - Buck voltage code is seven bits; this bank holds no buck voltage register
// RL19 - Reserved bits read zero, writes ignored
`default_nettype none
module rmc_bank #(
	parameter int DLY_1P5_CYC = rmc_pkg::DLY_1P5_US * rmc_pkg::CLK_MHZ,
	parameter int DLY_3_CYC   = rmc_pkg::DLY_3_US * rmc_pkg::CLK_MHZ,
	parameter int DLY_6_CYC   = rmc_pkg::DLY_6_US * rmc_pkg::CLK_MHZ
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        check_load,
	input  wire logic        reg_wr_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wr_data,
	output logic      [7:0]  reg_rd_data,
	input  wire logic        control_pin_one,
	input  wire logic        control_pin_two,
	input  wire logic        control_pin_three,
	input  wire logic [2:0]  buck_main_ctrl [0:6],
	input  wire logic [4:0]  lin_nvm_output_voltage_code [0:7],
	input  wire logic [7:0]  lin_nvm_bypass,
	input  wire logic        lin3_nvm_termination,
	input  wire logic [2:0]  linear_startup_rank [0:7],
	output logic      [14:0] alt_mode_active,
	output logic      [14:0] regulator_force_off,
	output logic      [6:0]  buck_en_out,
	output logic      [1:0]  buck_mode_out [0:6],
	output logic      [7:0]  lin_en_out,
	output logic      [7:0]  lin_bypass_out,
	output logic      [4:0]  lin_output_voltage_code_out [0:7],
	output logic             lin1_supply_sel_out,
	output logic             lin3_termination_out
);
	localparam int CW = rmc_pkg::DLY_CNT_W;

	logic [7:0]    pin_reg [0:14];
	logic [2:0]    buck_alt_reg [0:6];
	logic [7:0]    lin_main_reg [0:7];
	logic [7:0]    lin_alt_reg [0:7];
	logic [7:0]    lin_dflt [0:7];
	logic [14:0]   lvl_reg;
	logic [CW-1:0] cnt_reg [0:14];
	logic [14:0]   raw_pin;
	logic [14:0]   alt_sel;
	logic [14:0]   force_now;
	logic [7:0]    rd_next;
	logic [7:0]    rd_data_reg;
	logic [14:0]   alt_reg;
	logic [14:0]   force_reg;
	logic [6:0]    buck_en_reg;
	logic [1:0]    buck_mode_reg [0:6];
	logic [7:0]    lin_en_reg;
	logic [7:0]    lin_bypass_reg;
	logic [4:0]    lin_output_voltage_code_reg [0:7];
	logic          lin1_sup_reg;
	logic          lin3_term_reg;

	function automatic logic [CW-1:0] dly_cycles(input logic [1:0] code);
		unique case (code)
			rmc_pkg::RMC_DLY_NONE: dly_cycles = '0;
			rmc_pkg::RMC_DLY_1P5:  dly_cycles = CW'(DLY_1P5_CYC);
			rmc_pkg::RMC_DLY_3:    dly_cycles = CW'(DLY_3_CYC);
			rmc_pkg::RMC_DLY_6:    dly_cycles = CW'(DLY_6_CYC);
		endcase
	endfunction

	default clocking rmc_cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	// Per regulator: pin register, shift delay filter, mode selection
	for (genvar g = 0; g < rmc_pkg::NUM_REG; g++)
	begin : g_reg
		logic [1:0]    sel;
		logic [1:0]    rise_code;
		logic [1:0]    fall_code;
		logic [CW-1:0] target;

		assign sel       = pin_reg[g][rmc_pkg::SEL_LSB +: 2];
		assign rise_code = pin_reg[g][rmc_pkg::RISE_LSB +: 2];
		assign fall_code = pin_reg[g][rmc_pkg::FALL_LSB +: 2];

		always_comb
		begin
			unique case (sel) // [RL6]
				rmc_pkg::RMC_SEL_NONE:  raw_pin[g] = 1'b0;
				rmc_pkg::RMC_SEL_ONE:   raw_pin[g] = control_pin_one;
				rmc_pkg::RMC_SEL_TWO:   raw_pin[g] = control_pin_two;
				rmc_pkg::RMC_SEL_THREE: raw_pin[g] = control_pin_three;
			endcase
		end

		// Rising edge uses the rise delay, falling edge the fall delay
		assign target = raw_pin[g] ? dly_cycles(rise_code)
			: dly_cycles(fall_code); // [RL4] [RL5]

		// Reset enable takes priority over pin control
		assign force_now[g] = pin_reg[g][rmc_pkg::PIN_RST_BIT]
			& lvl_reg[g]; // [RL7]
		assign alt_sel[g] = pin_reg[g][rmc_pkg::PIN_EN_BIT]
			& ~pin_reg[g][rmc_pkg::PIN_RST_BIT] & lvl_reg[g]; // [RL8] [RL9]

		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
				pin_reg[g] <= rmc_pkg::PIN_RESET_VAL;
			else if (check_load)
				pin_reg[g] <= rmc_pkg::PIN_RESET_VAL; // [RL3]
			else if (reg_wr_en && reg_addr == rmc_pkg::PIN_ADDR[g])
				pin_reg[g] <= reg_wr_data;
		end

		// Filtered pin level changes once the change has held long enough
		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
			begin
				lvl_reg[g] <= 1'b0;
				cnt_reg[g] <= '0;
			end
			else if (check_load || raw_pin[g] == lvl_reg[g])
			begin
				lvl_reg[g] <= check_load ? 1'b0 : lvl_reg[g];
				cnt_reg[g] <= '0;
			end
			else if (target == '0 || cnt_reg[g] == target - CW'(1))
			begin
				lvl_reg[g] <= raw_pin[g]; // [RL4] [RL5]
				cnt_reg[g] <= '0;
			end
			else
				cnt_reg[g] <= cnt_reg[g] + CW'(1);
		end

		chk_sel_none_idle: assert property (
			sel == rmc_pkg::RMC_SEL_NONE && !lvl_reg[g] |=> !lvl_reg[g])
			else $error("unselected pin moved the level"); // [RL6]
		chk_rise_immediate: assert property (
			!check_load && !lvl_reg[g] && raw_pin[g]
			&& rise_code == rmc_pkg::RMC_DLY_NONE |=> lvl_reg[g])
			else $error("zero rise delay not immediate"); // [RL4]
		chk_fall_delayed: assert property (
			!check_load && lvl_reg[g] && !raw_pin[g] && cnt_reg[g] == '0
			&& fall_code != rmc_pkg::RMC_DLY_NONE |=> lvl_reg[g])
			else $error("fall delay skipped"); // [RL5]
		chk_pin_reset_off: assert property (
			force_now[g] |=> force_reg[g] && !alt_reg[g])
			else $error("pin reset did not force off"); // [RL7]
		chk_main_follow: assert property (
			!pin_reg[g][rmc_pkg::PIN_EN_BIT] || !lvl_reg[g]
			|=> !alt_reg[g])
			else $error("alternate mode without request"); // [RL8] [RL9]
	end

	// Switching regulator alternate control registers
	for (genvar b = 0; b < rmc_pkg::NUM_BUCK; b++)
	begin : g_buck
		logic wr_hit;

		assign wr_hit = reg_wr_en && reg_addr == rmc_pkg::BUCK_ALT_ADDR[b];

		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
				buck_alt_reg[b] <= rmc_pkg::BUCK_ALT_RESET_VAL;
			else if (check_load || force_now[b])
				buck_alt_reg[b] <= buck_main_ctrl[b]; // [RL2] [RL3] [RL7]
			else if (wr_hit)
			begin
				buck_alt_reg[b][rmc_pkg::EN_BIT] <=
					reg_wr_data[rmc_pkg::EN_BIT];
				// Reserved mode code is refused; the old mode stays
				if (reg_wr_data[rmc_pkg::MODE_LSB +: 2]
					!= rmc_pkg::RMC_MODE_RESERVED)
					buck_alt_reg[b][rmc_pkg::MODE_LSB +: 2] <=
						reg_wr_data[rmc_pkg::MODE_LSB +: 2]; // [RL1] [RL19]
			end
		end

		// Applied settings: alternate only while in alternate mode
		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
			begin
				buck_en_reg[b]   <= 1'b0;
				buck_mode_reg[b] <= rmc_pkg::RMC_MODE_HIGH_POWER;
			end
			else
			begin
				buck_en_reg[b] <= ~force_now[b] & (alt_sel[b]
					? buck_alt_reg[b][rmc_pkg::EN_BIT]
					: buck_main_ctrl[b][rmc_pkg::EN_BIT]); // [RL7] [RL10]
				buck_mode_reg[b] <= alt_sel[b]
					? buck_alt_reg[b][rmc_pkg::MODE_LSB +: 2]
					: buck_main_ctrl[b][rmc_pkg::MODE_LSB +: 2]; // [RL10]
			end
		end

		chk_mode_legal: assert property (
			buck_alt_reg[b][rmc_pkg::MODE_LSB +: 2]
			!= rmc_pkg::RMC_MODE_RESERVED || $past(check_load)
			|| $past(force_now[b]))
			else $error("reserved mode code stored"); // [RL1]
		chk_buck_alt_dflt: assert property (
			check_load |=> buck_alt_reg[b] == $past(buck_main_ctrl[b]))
			else $error("alternate default differs from main"); // [RL2]
		chk_alt_applied: assert property (
			alt_sel[b] && !force_now[b] |=> buck_mode_reg[b]
			== $past(buck_alt_reg[b][rmc_pkg::MODE_LSB +: 2]))
			else $error("alternate mode not applied"); // [RL10]
	end

	// Linear regulator main and alternate control registers
	for (genvar l = 0; l < rmc_pkg::NUM_LIN; l++)
	begin : g_lin
		localparam int RI = rmc_pkg::NUM_BUCK + l;
		logic [7:0] src;
		logic       term_dflt;

		assign term_dflt = (l == rmc_pkg::LIN3_IDX) & lin3_nvm_termination;
		// Enable default is set for any nonzero startup rank
		assign lin_dflt[l] = {term_dflt, lin_nvm_bypass[l], lin_nvm_output_voltage_code[l],
			linear_startup_rank[l] != 3'h0}
			& rmc_pkg::LIN_MAIN_MASK[l]; // [RL12] [RL13] [RL15]

		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
			begin
				lin_main_reg[l] <= rmc_pkg::LIN_RESET_VAL;
				lin_alt_reg[l]  <= rmc_pkg::LIN_RESET_VAL;
			end
			else if (check_load || force_now[RI])
			begin
				lin_main_reg[l] <= lin_dflt[l]; // [RL3] [RL7]
				lin_alt_reg[l]  <= lin_dflt[l]
					& rmc_pkg::LIN_ALT_MASK[l]; // [RL14]
			end
			else if (reg_wr_en)
			begin
				if (rmc_pkg::LIN_MAIN_PRESENT[l]
					&& reg_addr == rmc_pkg::LIN_MAIN_ADDR[l])
					lin_main_reg[l] <= reg_wr_data
						& rmc_pkg::LIN_MAIN_MASK[l]; // [RL19]
				if (rmc_pkg::LIN_ALT_PRESENT[l]
					&& reg_addr == rmc_pkg::LIN_ALT_ADDR[l])
					lin_alt_reg[l] <= reg_wr_data
						& rmc_pkg::LIN_ALT_MASK[l]; // [RL19]
			end
		end

		assign src = (alt_sel[RI] && rmc_pkg::LIN_ALT_PRESENT[l])
			? lin_alt_reg[l] : lin_main_reg[l]; // [RL9] [RL10]

		always_ff @(posedge sys_clk or negedge nrst)
		begin
			if (!nrst)
			begin
				lin_en_reg[l]     <= 1'b0;
				lin_bypass_reg[l] <= 1'b0;
				lin_output_voltage_code_reg[l]   <= '0;
			end
			else
			begin
				lin_en_reg[l] <= ~force_now[RI]
					& src[rmc_pkg::EN_BIT]; // [RL7]
				// Termination mode wins over pass-through on linear three
				lin_bypass_reg[l] <= src[rmc_pkg::BYPASS_BIT]
					& ~(l == rmc_pkg::LIN3_IDX
					&& src[rmc_pkg::TOP_BIT]); // [RL11] [RL17]
				lin_output_voltage_code_reg[l] <= src[rmc_pkg::OUTPUT_VOLTAGE_CODE_MSB:rmc_pkg::OUTPUT_VOLTAGE_CODE_LSB];
			end
		end

		chk_lin_force_off: assert property (
			force_now[RI] |=> !lin_en_reg[l])
			else $error("pin reset left linear regulator on"); // [RL7]
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lin1_sup_reg  <= 1'b0;
			lin3_term_reg <= 1'b0;
		end
		else
		begin
			lin1_sup_reg <= alt_sel[rmc_pkg::NUM_BUCK + rmc_pkg::LIN1_IDX]
				? lin_alt_reg[rmc_pkg::LIN1_IDX][rmc_pkg::TOP_BIT]
				: lin_main_reg[rmc_pkg::LIN1_IDX][rmc_pkg::TOP_BIT]; // [RL15]
			lin3_term_reg <=
				lin_main_reg[rmc_pkg::LIN3_IDX][rmc_pkg::TOP_BIT]; // [RL16]
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			alt_reg   <= '0;
			force_reg <= '0;
		end
		else
		begin
			alt_reg   <= alt_sel;
			force_reg <= force_now;
		end
	end

	// Read decode; unmapped addresses and reserved bits read zero
	always_comb
	begin
		rd_next = 8'h00;
		for (int k = 0; k < rmc_pkg::NUM_BUCK; k++)
			if (reg_addr == rmc_pkg::BUCK_ALT_ADDR[k])
				rd_next = {5'h00, buck_alt_reg[k]}; // [RL19]
		for (int k = 0; k < rmc_pkg::NUM_REG; k++)
			if (reg_addr == rmc_pkg::PIN_ADDR[k])
				rd_next = pin_reg[k];
		for (int k = 0; k < rmc_pkg::NUM_LIN; k++)
		begin
			if (rmc_pkg::LIN_MAIN_PRESENT[k]
				&& reg_addr == rmc_pkg::LIN_MAIN_ADDR[k])
				rd_next = lin_main_reg[k];
			if (rmc_pkg::LIN_ALT_PRESENT[k]
				&& reg_addr == rmc_pkg::LIN_ALT_ADDR[k])
				rd_next = lin_alt_reg[k];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			rd_data_reg <= 8'h00;
		else
			rd_data_reg <= rd_next;
	end

	chk_term_precedence: assert property (
		lin_main_reg[rmc_pkg::LIN3_IDX][rmc_pkg::TOP_BIT]
		&& !alt_sel[rmc_pkg::NUM_BUCK + rmc_pkg::LIN3_IDX]
		|=> lin3_term_reg && !lin_bypass_reg[rmc_pkg::LIN3_IDX])
		else $error("pass-through beat termination"); // [RL16] [RL17]
	chk_reserved_zero: assert property (
		reg_addr == rmc_pkg::BUCK_ALT_ADDR[0] |=> rd_data_reg[7:3] == 5'h00)
		else $error("reserved bits read nonzero"); // [RL19]
	chk_lin_main_dflt: assert property (
		check_load |=> lin_main_reg[1] == $past(lin_dflt[1]))
		else $error("linear default not loaded"); // [RL3] [RL13]

	assign reg_rd_data          = rd_data_reg;
	assign alt_mode_active      = alt_reg;
	assign regulator_force_off  = force_reg;
	assign buck_en_out          = buck_en_reg;
	assign buck_mode_out        = buck_mode_reg;
	assign lin_en_out           = lin_en_reg;
	assign lin_bypass_out       = lin_bypass_reg;
	assign lin_output_voltage_code_out         = lin_output_voltage_code_reg;
	assign lin1_supply_sel_out  = lin1_sup_reg;
	assign lin3_termination_out = lin3_term_reg;
endmodule
`default_nettype wire

//--- verilog/rmc_pkg.sv
// Constants for the regulator mode control register bank
`default_nettype none
package rmc_pkg;
	localparam int NUM_BUCK = 7;
	localparam int NUM_LIN  = 8;
	localparam int NUM_REG  = 15;

	// Register byte addresses
	localparam logic [7:0] BUCK_ALT_ADDR [0:6] = '{8'h23, 8'h28, 8'h2D,
		8'h32, 8'h37, 8'h3C, 8'h41};
	localparam logic [7:0] PIN_ADDR [0:14] = '{8'h24, 8'h29, 8'h2E, 8'h33,
		8'h38, 8'h3D, 8'h42, 8'h4E, 8'h51, 8'h54, 8'h57, 8'h5A, 8'h5D,
		8'h60, 8'h63};
	localparam logic [7:0] LIN_MAIN_ADDR [0:7] = '{8'h4C, 8'h4F, 8'h52,
		8'h00, 8'h58, 8'h5B, 8'h5E, 8'h61};
	localparam logic [7:0] LIN_ALT_ADDR [0:7] = '{8'h4D, 8'h50, 8'h00,
		8'h00, 8'h59, 8'h5C, 8'h5F, 8'h62};
	// Which linear regulators own a main / alternate register in this bank
	localparam logic [7:0] LIN_MAIN_PRESENT = 8'hF7;
	localparam logic [7:0] LIN_ALT_PRESENT  = 8'hF3;
	// Writable bits; all others are reserved and read zero
	localparam logic [7:0] LIN_MAIN_MASK [0:7] = '{8'h81, 8'h7F, 8'hFF,
		8'h00, 8'h7F, 8'h7F, 8'h7F, 8'h7F};
	localparam logic [7:0] LIN_ALT_MASK [0:7] = '{8'h81, 8'h7F, 8'h00,
		8'h00, 8'h7F, 8'h7F, 8'h7F, 8'h7F};
	localparam logic [7:0] PIN_RESET_VAL = 8'h00;
	localparam logic [2:0] BUCK_ALT_RESET_VAL = 3'h0;
	localparam logic [7:0] LIN_RESET_VAL = 8'h00;

	// Field positions
	localparam int EN_BIT     = 0;
	localparam int MODE_LSB   = 1;
	localparam int OUTPUT_VOLTAGE_CODE_LSB   = 1;
	localparam int OUTPUT_VOLTAGE_CODE_MSB   = 5;
	localparam int BYPASS_BIT = 6;
	localparam int TOP_BIT    = 7;
	localparam int PIN_EN_BIT  = 0;
	localparam int PIN_RST_BIT = 1;
	localparam int SEL_LSB     = 2;
	localparam int FALL_LSB    = 4;
	localparam int RISE_LSB    = 6;
	localparam int LIN1_IDX    = 0;
	localparam int LIN3_IDX    = 2;

	typedef enum logic [1:0] {
		RMC_MODE_HIGH_POWER  = 2'h0,
		RMC_MODE_LOW_POWER   = 2'h1,
		RMC_MODE_FIXED_FREQ  = 2'h2,
		RMC_MODE_RESERVED    = 2'h3
	} rmc_mode_t;

	typedef enum logic [1:0] {
		RMC_DLY_NONE = 2'h0,
		RMC_DLY_1P5  = 2'h1,
		RMC_DLY_3    = 2'h2,
		RMC_DLY_6    = 2'h3
	} rmc_dly_t;

	typedef enum logic [1:0] {
		RMC_SEL_NONE  = 2'h0,
		RMC_SEL_ONE   = 2'h1,
		RMC_SEL_TWO   = 2'h2,
		RMC_SEL_THREE = 2'h3
	} rmc_sel_t;

	// Shift delays in microseconds and the clock rate
	localparam int DLY_1P5_US = 1500;
	localparam int DLY_3_US   = 3000;
	localparam int DLY_6_US   = 6000;
	localparam int CLK_MHZ    = 40;
	localparam int DLY_CNT_W  = 18;
endpackage
`default_nettype wire
